// ===== design/fcd_defs.svh
// register offsets, field positions, reset values and sizes of the dma controller
`ifndef FCD_DEFS_SVH
`define FCD_DEFS_SVH
`define FCD_RA_CMD 4'h8
`define FCD_RA_REQ 4'h9
`define FCD_RA_MSK1 4'hA
`define FCD_RA_MODE 4'hB
`define FCD_RA_CLRFF 4'hC
`define FCD_RA_MCLR 4'hD
`define FCD_RA_CLRMSK 4'hE
`define FCD_RA_MSKALL 4'hF
`define FCD_CMD_M2M 0
`define FCD_CMD_DIS 2
`define FCD_CMD_CMP 3
`define FCD_CMD_ROT 4
`define FCD_CMD_EXW 5
`define FCD_CMD_DRQLO 6
`define FCD_CMD_DAKHI 7
`define FCD_MD_AUTO 2
`define FCD_MD_DEC 3
`define FCD_T_WR 2'h1
`define FCD_T_RD 2'h2
`define FCD_M_DEMAND 2'h0
`define FCD_M_SINGLE 2'h1
`define FCD_M_BLOCK 2'h2
`define FCD_M_CASC 2'h3
`define FCD_CMD_RST 8'h00
`define FCD_MASK_RST 4'hF
`define FCD_FIFO_W 8
`define FCD_FIFO_D 32
`endif

// ===== design/fcd_pkg.sv
// types shared by the dma controller
package fcd_pkg;
  typedef enum logic [4:0] {
    ST_IDLE, ST_S0, ST_S1, ST_S2, ST_S3, ST_SW, ST_S4, ST_CASC,
    ST_S11, ST_S12, ST_S13, ST_S14, ST_S21, ST_S22, ST_S23, ST_S24
  } fcd_state_t;
  typedef struct packed {
    logic memory_read_strobe;
    logic memory_write_strobe;
    logic io_read_strobe;
    logic io_write_strobe;
  } fcd_strobe_t;
endpackage

// ===== design/fcd_top.sv
// four-channel dma controller: input synchroniser, data fifo and controller
`timescale 1ns/100ps
`include "fcd_defs.svh"

// ************************************************************
// input synchroniser
// ************************************************************
module fcd_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      q_o <= INIT;
    end else begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
      // a bit moves only where the two later stages agree
      q_o <= (s3 & ~(s2 ^ s3)) | (q_o & (s2 ^ s3));
    end
  end
endmodule

// ************************************************************
// data fifo
// ************************************************************
module fcd_fifo #(
  parameter int W = `FCD_FIFO_W,
  parameter int D = `FCD_FIFO_D
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0] wp;
  logic [AW:0] rp;
  assign in_ready_o = !((wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]));
  assign out_valid_o = (wp != rp);
  assign out_data_o = mem[rp[AW-1:0]];
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wp <= '0;
      rp <= '0;
    end else begin
      if (in_valid_i && in_ready_o) begin
        mem[wp[AW-1:0]] <= in_data_i;
        wp <= wp + 1'h1;
      end
      if (out_valid_o && out_ready_i) begin
        rp <= rp + 1'h1;
      end
    end
  end
endmodule

// ************************************************************
// controller
// ************************************************************
// Summary of operation
// - each channel address steps up or down after every transfer, kept in place
// - word count holds transfers minus one, decrements, terminal count at zero
// - base and current written together bytewise; autoinit copies base back
// - command register written only while idle, cleared by reset
// - mode write uses data bits 0 and 1 to pick the channel
// - software request bits set or cleared singly, cleared by end or reset
// - mask blocks hardware requests, set at end without autoinit, set by reset
// - status shows terminal count and pending request for each channel
// - temporary register holds memory-to-memory data, readable when idle
// - idle, hold wait, working states, waits before the last, two-digit memory states
// - idle samples requests and selects; unmasked request raises hold request
// - single mode moves one byte per hold handshake then drops hold request
// - block mode runs until terminal count or external end
// - demand mode also stops when the request drops, resumes on reassert
// - cascade passes a second controller's hold through request and acknowledge
// - write, read and verify transfers drive their strobe pairs or none
// - memory move uses channel 0 source, channel 1 destination and count
// - upper address goes out on data lines in S1, S11 or S21, at the start of a service and when it changes
// - compressed timing drops S3, two clocks per transfer
// - fixed priority channel 0 first, rotating puts last served lowest
// - clear byte pointer command resets the first/last flip-flop
// - master clear acts as reset on command, status, request, temp, pointer, mask
// - external end stops the channel, sets its status bit, clears its request
// - at most one acknowledge active, and only while owning the bus
module fcd_top import fcd_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic ior_n_i,
  output logic ior_n_o,
  output logic ior_oe_o,
  input wire logic iow_n_i,
  output logic iow_n_o,
  output logic iow_oe_o,
  input wire logic [3:0] addr_lo_i,
  output logic [3:0] addr_lo_o,
  output logic addr_lo_oe_o,
  output logic [3:0] addr_hi_o,
  output logic addr_hi_oe_o,
  input wire logic [7:0] db_i,
  output logic [7:0] db_o,
  output logic db_oe_o,
  output logic memory_read_strobe_n_o,
  output logic memory_write_strobe_n_o,
  input wire logic ready_i,
  input wire logic bus_hold_grant_i,
  output logic bus_hold_request_o,
  output logic upper_address_strobe_o,
  output logic address_output_enable_o,
  input wire logic [3:0] channel_request_i,
  output logic [3:0] channel_acknowledge_o,
  input wire logic end_of_process_n_i,
  output logic end_of_process_n_o,
  output logic end_of_process_oe_o
);
  logic [21:0] sync_q;
  logic s_cs_n, s_ior_n, s_iow_n, s_bus_hold_grant, s_rdy, s_eop_n;
  logic [3:0] s_a;
  logic [7:0] s_db;
  logic [3:0] s_channel_request;
  fcd_state_t st, next_st;
  fcd_strobe_t nstb;
  logic [15:0] cur_addr [4];
  logic [15:0] cur_cnt [4];
  logic [15:0] base_addr [4];
  logic [15:0] base_cnt [4];
  logic [5:0] mode [4];
  logic [7:0] cmd, temp, rd_data;
  logic [3:0] sreq, mask, tc_st, channel_request_act, req_all, end_hit, auto_vec;
  logic [1:0] ch, last_ch, win, start_ch, a_ch, nx_ch, cnt_ch, xtype, xmode;
  logic [7:0] hi_lat;
  logic ff, m2m, found, prev_ior, prev_iow, cpu_ok, reg_wr, reg_rd, mclr, clr;
  logic [15:0] a_cur, a_next, c_cur, out_addr, cnt_sel;
  logic tc_now, xfer_done, end_svc, fifo_in_rdy, fifo_out_vld, rd_on, wr_on;
  logic [7:0] fifo_dout;
  logic go;

  fcd_sync #(.W(22), .INIT(22'h380003)) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .d_i({cs_n_i, ior_n_i, iow_n_i, addr_lo_i, db_i, channel_request_i, bus_hold_grant_i, ready_i,
          end_of_process_n_i}),
    .q_o(sync_q)
  );
  assign {s_cs_n, s_ior_n, s_iow_n, s_a, s_db, s_channel_request, s_bus_hold_grant, s_rdy, s_eop_n} = sync_q;

  // memory move data waits here between read and write halves
  fcd_fifo #(.W(`FCD_FIFO_W), .D(`FCD_FIFO_D)) u_fifo (
    .ref_clk_i(ref_clk_i),
    .rst_i(clr),
    .in_valid_i(st == ST_S14),
    .in_ready_o(fifo_in_rdy),
    .in_data_i(s_db),
    .out_valid_o(fifo_out_vld),
    .out_ready_i(st == ST_S22),
    .out_data_o(fifo_dout)
  );

  // ************************************************************
  // processor access
  // ************************************************************
  // the pins lag four clocks, so access edges are taken from the synchronised copies
  assign cpu_ok = (st == ST_IDLE) && !s_cs_n;
  assign reg_wr = cpu_ok && s_iow_n && !prev_iow;
  assign reg_rd = cpu_ok && s_ior_n && !prev_ior;
  assign mclr = reg_wr && (s_a == `FCD_RA_MCLR);
  assign clr = rst_i || mclr;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      prev_ior <= 1'h1;
      prev_iow <= 1'h1;
    end else begin
      prev_ior <= s_ior_n;
      prev_iow <= s_iow_n;
    end
  end

  always_comb begin
    rd_data = 8'h00;
    cnt_sel = s_a[0] ? cur_cnt[s_a[2:1]] : cur_addr[s_a[2:1]];
    if (!s_a[3]) begin
      rd_data = ff ? cnt_sel[15:8] : cnt_sel[7:0];
    end else if (s_a == `FCD_RA_CMD) begin
      rd_data = {channel_request_act, tc_st};
    end else if (s_a == `FCD_RA_MCLR) begin
      rd_data = temp;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (clr) begin
      cmd <= `FCD_CMD_RST;
    end else if (reg_wr && (s_a == `FCD_RA_CMD)) begin
      cmd <= s_db;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 4; i++) begin
        mode[i] <= 6'h00;
      end
    end else if (reg_wr && (s_a == `FCD_RA_MODE)) begin
      mode[s_db[1:0]] <= s_db[7:2];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (clr || (reg_wr && (s_a == `FCD_RA_CLRFF))) begin
      ff <= 1'h0;
    end else if ((reg_wr || reg_rd) && !s_a[3]) begin
      ff <= ~ff;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (clr) begin
      temp <= 8'h00;
    end else if ((st == ST_S22) && fifo_out_vld) begin
      temp <= fifo_dout;
    end
  end

  // ************************************************************
  // request, mask and status
  // ************************************************************
  assign channel_request_act = cmd[`FCD_CMD_DRQLO] ? ~s_channel_request : s_channel_request;
  assign req_all = (cmd[`FCD_CMD_DIS] ? 4'h0 : (channel_request_act & ~mask)) | sreq;
  assign end_hit = m2m ? 4'h3 : 4'(4'h1 << ch);
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      auto_vec[i] = mode[i][`FCD_MD_AUTO];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (clr) begin
      sreq <= 4'h0;
      mask <= `FCD_MASK_RST;
      tc_st <= 4'h0;
    end else begin
      if (reg_rd && (s_a == `FCD_RA_CMD)) begin
        tc_st <= 4'h0;
      end
      if (reg_wr && (s_a == `FCD_RA_REQ)) begin
        sreq[s_db[1:0]] <= s_db[2];
      end
      if (reg_wr && (s_a == `FCD_RA_MSK1)) begin
        mask[s_db[1:0]] <= s_db[2];
      end
      if (reg_wr && (s_a == `FCD_RA_CLRMSK)) begin
        mask <= 4'h0;
      end
      if (reg_wr && (s_a == `FCD_RA_MSKALL)) begin
        mask <= s_db[3:0];
      end
      if (end_svc) begin
        tc_st <= tc_st | end_hit;
        sreq <= sreq & ~end_hit;
        mask <= mask | (end_hit & ~auto_vec);
      end
    end
  end

  // fixed order from channel 0, or from the one after the last served
  always_comb begin
    start_ch = cmd[`FCD_CMD_ROT] ? 2'(last_ch + 2'h1) : 2'h0;
    win = 2'h0;
    found = 1'h0;
    for (int i = 3; i >= 0; i--) begin
      if (req_all[2'(start_ch + 2'(i))]) begin
        win = 2'(start_ch + 2'(i));
        found = 1'h1;
      end
    end
  end

  // ************************************************************
  // transfer sequencing
  // ************************************************************
  // the synchronised grant lags the pin, so a stale grant must drain before a new hold
  assign go = found && !s_bus_hold_grant;
  assign xtype = mode[ch][1:0];
  assign xmode = mode[ch][5:4];
  assign a_ch = m2m ? ((st inside {ST_S21, ST_S22, ST_S23, ST_S24}) ? 2'h1 : 2'h0) : ch;
  assign nx_ch = m2m ? ((next_st inside {ST_S21, ST_S22, ST_S23, ST_S24}) ? 2'h1 : 2'h0) : ch;
  assign a_cur = cur_addr[a_ch];
  assign a_next = mode[a_ch][`FCD_MD_DEC] ? 16'(a_cur - 16'h1) : 16'(a_cur + 16'h1);
  assign cnt_ch = m2m ? 2'h1 : ch;
  assign c_cur = cur_cnt[cnt_ch];
  assign tc_now = (c_cur == 16'h0);
  assign xfer_done = (st == ST_S4) || (st == ST_S24);
  assign end_svc = xfer_done && (tc_now || !s_eop_n);
  assign out_addr = (st == ST_S4) ? a_next : cur_addr[nx_ch];

  always_comb begin
    next_st = st;
    unique case (st)
      ST_IDLE: if (go) next_st = ST_S0;
      ST_S0: if (s_bus_hold_grant) next_st = m2m ? ST_S11 : ((xmode == `FCD_M_CASC) ? ST_CASC : ST_S1);
      ST_S1: next_st = ST_S2;
      ST_S2: next_st = cmd[`FCD_CMD_CMP] ? (s_rdy ? ST_S4 : ST_SW) : ST_S3;
      ST_S3: next_st = s_rdy ? ST_S4 : ST_SW;
      ST_SW: next_st = s_rdy ? ST_S4 : ST_SW;
      ST_S4: begin
        if (end_svc || (xmode == `FCD_M_SINGLE)) begin
          next_st = ST_IDLE;
        end else if ((xmode == `FCD_M_BLOCK) || channel_request_act[ch]) begin
          next_st = (a_next[15:8] != a_cur[15:8]) ? ST_S1 : ST_S2;
        end else begin
          next_st = ST_IDLE;
        end
      end
      ST_CASC: next_st = channel_request_act[ch] ? ST_CASC : ST_IDLE;
      ST_S11: next_st = ST_S12;
      ST_S12: next_st = ST_S13;
      ST_S13: next_st = s_rdy ? ST_S14 : ST_S13;
      ST_S14: if (fifo_in_rdy) next_st = (hi_lat == cur_addr[1][15:8]) ? ST_S22 : ST_S21;
      ST_S21: next_st = ST_S22;
      ST_S22: if (fifo_out_vld) next_st = ST_S23;
      ST_S23: next_st = s_rdy ? ST_S24 : ST_S23;
      ST_S24: next_st = end_svc ? ST_IDLE : ((hi_lat == cur_addr[0][15:8]) ? ST_S12 : ST_S11);
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st <= ST_IDLE;
      ch <= 2'h0;
      last_ch <= 2'h0;
      m2m <= 1'h0;
      hi_lat <= 8'h00;
    end else begin
      st <= next_st;
      if ((st == ST_IDLE) && go) begin
        m2m <= cmd[`FCD_CMD_M2M] && sreq[0];
        ch <= (cmd[`FCD_CMD_M2M] && sreq[0]) ? 2'h0 : win;
        last_ch <= (cmd[`FCD_CMD_M2M] && sreq[0]) ? 2'h1 : win;
      end
      if (st inside {ST_S1, ST_S11, ST_S21}) begin
        hi_lat <= a_cur[15:8];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 4; i++) begin
        cur_addr[i] <= 16'h0000;
        cur_cnt[i] <= 16'h0000;
        base_addr[i] <= 16'h0000;
        base_cnt[i] <= 16'h0000;
      end
    end else begin
      if (reg_wr && !s_a[3] && !s_a[0]) begin
        if (ff) begin
          cur_addr[s_a[2:1]][15:8] <= s_db;
          base_addr[s_a[2:1]][15:8] <= s_db;
        end else begin
          cur_addr[s_a[2:1]][7:0] <= s_db;
          base_addr[s_a[2:1]][7:0] <= s_db;
        end
      end
      if (reg_wr && !s_a[3] && s_a[0]) begin
        if (ff) begin
          cur_cnt[s_a[2:1]][15:8] <= s_db;
          base_cnt[s_a[2:1]][15:8] <= s_db;
        end else begin
          cur_cnt[s_a[2:1]][7:0] <= s_db;
          base_cnt[s_a[2:1]][7:0] <= s_db;
        end
      end
      if ((st == ST_S14) && fifo_in_rdy) begin
        cur_addr[0] <= a_next;
      end
      if (xfer_done) begin
        cur_addr[a_ch] <= a_next;
        cur_cnt[cnt_ch] <= 16'(c_cur - 16'h1);
      end
      for (int i = 0; i < 4; i++) begin
        if (end_svc && end_hit[i] && auto_vec[i]) begin
          cur_addr[i] <= base_addr[i];
          cur_cnt[i] <= base_cnt[i];
        end
      end
    end
  end

  // ************************************************************
  // pin drive
  // ************************************************************
  always_comb begin
    nstb = '0;
    rd_on = next_st inside {ST_S3, ST_SW, ST_S4};
    wr_on = (next_st == ST_S4) || (cmd[`FCD_CMD_EXW] && (next_st inside {ST_S3, ST_SW}));
    if (m2m) begin
      nstb.memory_read_strobe = next_st inside {ST_S13, ST_S14};
      nstb.memory_write_strobe = next_st inside {ST_S23, ST_S24};
    end else if (xtype == `FCD_T_WR) begin
      nstb.io_read_strobe = rd_on;
      nstb.memory_write_strobe = wr_on;
    end else if (xtype == `FCD_T_RD) begin
      nstb.memory_read_strobe = rd_on;
      nstb.io_write_strobe = wr_on;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      bus_hold_request_o <= 1'h0;
      address_output_enable_o <= 1'h0;
      upper_address_strobe_o <= 1'h0;
      channel_acknowledge_o <= 4'hF;
      {memory_read_strobe_n_o, memory_write_strobe_n_o, ior_n_o, iow_n_o} <= 4'hF;
      {ior_oe_o, iow_oe_o, addr_lo_oe_o, addr_hi_oe_o} <= 4'h0;
      addr_lo_o <= 4'h0;
      addr_hi_o <= 4'h0;
      db_o <= 8'h00;
      db_oe_o <= 1'h0;
      end_of_process_n_o <= 1'h0;
      end_of_process_oe_o <= 1'h0;
    end else begin
      bus_hold_request_o <= (next_st != ST_IDLE);
      address_output_enable_o <= next_st inside {ST_S1, ST_S2, ST_S3, ST_SW, ST_S4, [ST_S11:ST_S24]};
      upper_address_strobe_o <= next_st inside {ST_S1, ST_S11, ST_S21};
      // one acknowledge at most, never before the grant has moved the state past S0
      if (!m2m && (next_st inside {ST_S1, ST_S2, ST_S3, ST_SW, ST_S4, ST_CASC})) begin
        channel_acknowledge_o <= cmd[`FCD_CMD_DAKHI] ? 4'(4'h1 << ch) : ~4'(4'h1 << ch);
      end else begin
        channel_acknowledge_o <= cmd[`FCD_CMD_DAKHI] ? 4'h0 : 4'hF;
      end
      {memory_read_strobe_n_o, memory_write_strobe_n_o, ior_n_o, iow_n_o} <= ~nstb;
      {ior_oe_o, iow_oe_o, addr_lo_oe_o, addr_hi_oe_o} <= {4{next_st inside {ST_S1, ST_S2, ST_S3, ST_SW,
                                                            ST_S4, [ST_S11:ST_S24]}}};
      addr_lo_o <= out_addr[3:0];
      addr_hi_o <= out_addr[7:4];
      if (next_st inside {ST_S1, ST_S11, ST_S21}) begin
        db_o <= out_addr[15:8];
      end else if ((st == ST_S22) && (next_st == ST_S23)) begin
        db_o <= fifo_dout;
      end else if (!(next_st inside {ST_S23, ST_S24})) begin
        db_o <= rd_data;
      end
      db_oe_o <= (next_st inside {ST_S1, ST_S11, ST_S21, ST_S23, ST_S24}) ||
                 ((next_st == ST_IDLE) && cpu_ok && !s_ior_n);
      end_of_process_oe_o <= (next_st inside {ST_S4, ST_S24}) && tc_now;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  logic [3:0] dk_act;
  assign dk_act = cmd[`FCD_CMD_DAKHI] ? channel_acknowledge_o : ~channel_acknowledge_o;
  property p_one_channel_acknowledge;
    @(posedge ref_clk_i) disable iff (rst_i) $onehot0(dk_act) && ((dk_act == 4'h0) || bus_hold_request_o);
  endproperty
  a_one_channel_acknowledge: assert property (p_one_channel_acknowledge) else $error("acknowledge not one-hot or without bus");
  property p_single_drop;
    @(posedge ref_clk_i) disable iff (rst_i) (st == ST_S4 && !m2m && xmode == `FCD_M_SINGLE) |=> !bus_hold_request_o;
  endproperty
  a_single_drop: assert property (p_single_drop) else $error("hold request kept after single");
  property p_cnt_dec;
    @(posedge ref_clk_i) disable iff (rst_i) (st == ST_S4 && !end_svc) |=> (c_cur == 16'($past(c_cur) - 16'h1));
  endproperty
  a_cnt_dec: assert property (p_cnt_dec) else $error("word count not decremented");
  property p_end_status;
    @(posedge ref_clk_i) disable iff (rst_i || mclr) (end_svc && !m2m) |=> (tc_st[$past(ch)] && !sreq[$past(ch)]);
  endproperty
  a_end_status: assert property (p_end_status) else $error("end did not set status");
  property p_mask_end;
    @(posedge ref_clk_i) disable iff (rst_i) (end_svc && !m2m && !auto_vec[ch]) |=> mask[$past(ch)];
  endproperty
  a_mask_end: assert property (p_mask_end) else $error("mask not set at end");
  property p_mclr;
    @(posedge ref_clk_i) mclr |=> (cmd == 8'h00 && mask == 4'hF && sreq == 4'h0 && !ff);
  endproperty
  a_mclr: assert property (p_mclr) else $error("master clear incomplete");
  property p_verify_quiet;
    @(posedge ref_clk_i) disable iff (rst_i) (!m2m && xtype == 2'h0 && st != ST_IDLE) |=>
      ({memory_read_strobe_n_o, memory_write_strobe_n_o, ior_n_o, iow_n_o} == 4'hF);
  endproperty
  a_verify_quiet: assert property (p_verify_quiet) else $error("strobe during verify");
  property p_hrq_req;
    @(posedge ref_clk_i) disable iff (rst_i) (st == ST_IDLE && go) |=> bus_hold_request_o ##1 bus_hold_request_o;
  endproperty
  a_hrq_req: assert property (p_hrq_req) else $error("request did not raise hold");
  property p_compress;
    @(posedge ref_clk_i) disable iff (rst_i) (st == ST_S2 && cmd[`FCD_CMD_CMP]) |=> (st == ST_S4 || st == ST_SW);
  endproperty
  a_compress: assert property (p_compress) else $error("S3 taken under compressed timing");
endmodule

// ===== sim/fcd_partner.sv
// host processor model: grants the bus hold and paces ready
`timescale 1ns/100ps
module fcd_partner (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire logic bus_hold_request_i,
  output logic bus_hold_grant_o,
  output logic ready_o
);
  logic [1:0] dly;
  logic [2:0] pace;
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      dly <= 2'h0;
      pace <= 3'h0;
    end else begin
      dly <= {dly[0], bus_hold_request_i};
      pace <= pace + 3'h1;
    end
  end
  // grant only once the buses are released, dropped with the request
  assign bus_hold_grant_o = dly[1] & bus_hold_request_i;
  // slow memory: ready low four clocks in eight, long enough to pass the input filter
  assign ready_o = ~slow_i | pace[2];
endmodule

// ===== sim/fcd_top_tb.sv
// self-checking testbench of the dma controller
`timescale 1ns/100ps
module fcd_top_tb;
  logic clk = 0, rst = 1, cs_n = 1, hir = 1, hiw = 1, slow = 0;
  logic [3:0] ad = 4'h0, req = 4'h0;
  logic [7:0] db = 8'h00, r;
  int n_mismatch = 0, n_checks = 0, n_mw, n_mr, n_io, n_bad, n_stb;
  logic [3:0] ack_seen;
  logic ior_n_o, ior_oe_o, iow_n_o, iow_oe_o, db_oe_o, memory_read_strobe_n_o, memory_write_strobe_n_o, bus_hold_request, grant, rdy, eop_n_o, eop_oe;
  logic addr_lo_oe_o, upper_address_strobe, address_output_enable;
  logic [3:0] addr_lo_o, ack;
  logic [7:0] db_o;
  wire ior_pin = ior_oe_o ? ior_n_o : hir;
  wire iow_pin = iow_oe_o ? iow_n_o : hiw;
  wire eop_pin = ~(eop_oe & ~eop_n_o);
  always #50 clk = ~clk;
  fcd_partner host (.ref_clk_i(clk), .rst_i(rst), .slow_i(slow), .bus_hold_request_i(bus_hold_request),
    .bus_hold_grant_o(grant), .ready_o(rdy));
  fcd_top dut (.ref_clk_i(clk), .rst_i(rst), .cs_n_i(cs_n), .ior_n_i(ior_pin), .ior_n_o(ior_n_o),
    .ior_oe_o(ior_oe_o), .iow_n_i(iow_pin), .iow_n_o(iow_n_o), .iow_oe_o(iow_oe_o),
    .addr_lo_i(addr_lo_oe_o ? addr_lo_o : ad), .addr_lo_o(addr_lo_o), .addr_lo_oe_o(addr_lo_oe_o),
    .addr_hi_o(), .addr_hi_oe_o(), .db_i(db_oe_o ? db_o : db), .db_o(db_o), .db_oe_o(db_oe_o),
    .memory_read_strobe_n_o(memory_read_strobe_n_o), .memory_write_strobe_n_o(memory_write_strobe_n_o), .ready_i(rdy), .bus_hold_grant_i(grant),
    .bus_hold_request_o(bus_hold_request), .upper_address_strobe_o(upper_address_strobe), .address_output_enable_o(address_output_enable),
    .channel_request_i(req), .channel_acknowledge_o(ack), .end_of_process_n_i(eop_pin),
    .end_of_process_n_o(eop_n_o), .end_of_process_oe_o(eop_oe));
  // bus activity seen during a service
  always @(posedge clk) begin
    if (memory_write_strobe_n_o === 1'b0) n_mw++;
    if (memory_read_strobe_n_o === 1'b0) n_mr++;
    if (ior_oe_o && ior_n_o === 1'b0) n_io++;
    if (ack !== 4'hF) ack_seen = ack_seen | ~ack;
    if (ack !== 4'hF && !grant) n_bad++;
    if (upper_address_strobe === 1'b1) n_stb++;
    if ((memory_read_strobe_n_o === 1'b0 || memory_write_strobe_n_o === 1'b0) && address_output_enable !== 1'b1) n_bad++;
  end
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %h expected %h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask
  // synchronisers need the pins steady for several clocks each level
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    cs_n = 0; ad = a; db = d; cyc(5); hiw = 0; cyc(6); hiw = 1; cyc(6); cs_n = 1; db = ~d; cyc(2);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    cs_n = 0; ad = a; cyc(2); hir = 0; cyc(7); d = db_o; hir = 1; cyc(7); cs_n = 1; cyc(2);
  endtask
  task automatic serve(input logic [3:0] ch);
    int i;
    int j;
    n_mw = 0; n_mr = 0; n_io = 0; n_bad = 0; n_stb = 0; ack_seen = 4'h0;
    for (i = 0; i < 60 && bus_hold_request !== 1'b1; i++) cyc(1);
    // a hold request that never rises must fail here, not slip past the second wait
    for (j = 0; j < 200 && bus_hold_request !== 1'b0; j++) cyc(1);
    chk(i < 60 && j < 200, 1'b1);
    chk(ack_seen, ch);
    chk(16'(n_bad), 16'h0);
  endtask
  task automatic t_reset;
    rd(4'h8, r); chk(r, 8'h00);
    rd(4'hD, r); chk(r, 8'h00);
  endtask
  task automatic t_single;
    wr(4'hC, 8'h00); wr(4'h0, 8'h34); wr(4'h0, 8'h12); wr(4'h1, 8'h00); wr(4'h1, 8'h00);
    wr(4'hC, 8'h00); rd(4'h0, r); chk(r, 8'h34); rd(4'h0, r); chk(r, 8'h12);
    wr(4'hB, 8'h44); wr(4'hA, 8'h00); slow = 1; req[0] = 1;
    serve(4'h1);
    chk(16'(n_mw), 16'h1);
    chk(16'(n_stb), 16'h1);
    chk({n_mr == 0, n_io > 0}, 2'h3);
    cyc(40); chk(bus_hold_request, 1'b0);
    req[0] = 0; slow = 0;
    rd(4'h8, r); chk(r[3:0], 4'h1);
    wr(4'hC, 8'h00); rd(4'h0, r); chk(r, 8'h35); rd(4'h0, r); chk(r, 8'h12);
    rd(4'h1, r); chk(r, 8'hFF); rd(4'h1, r); chk(r, 8'hFF);
  endtask
  task automatic t_soft_verify;
    wr(4'hD, 8'h00); rd(4'h8, r); chk(r, 8'h00);
    wr(4'h2, 8'h00); wr(4'h2, 8'h20); wr(4'h3, 8'h00); wr(4'h3, 8'h00);
    wr(4'hB, 8'h41); wr(4'h9, 8'h05);
    serve(4'h2);
    chk(16'(n_mw + n_mr + n_io), 16'h0);
    rd(4'h8, r); chk(r[3:0], 4'h2);
  endtask
  // channel 2: compressed, rotating, read type, autoinit, decrement, block, two bytes
  task automatic t_block;
    wr(4'h8, 8'h18);
    wr(4'hC, 8'h00);
    wr(4'h4, 8'h00);
    wr(4'h4, 8'h01);
    wr(4'h5, 8'h01);
    wr(4'h5, 8'h00);
    wr(4'hB, 8'hBA);
    wr(4'h9, 8'h06);
    serve(4'h4);
    chk(16'(n_mr), 16'h2);
    chk(16'(n_stb), 16'h2);
    chk(16'(n_mw), 16'h0);
    rd(4'h8, r);
    chk(r[3:0], 4'h4);
    wr(4'hC, 8'h00);
    rd(4'h4, r);
    chk(r, 8'h00);
    rd(4'h4, r);
    chk(r, 8'h01);
    rd(4'h5, r);
    chk(r, 8'h01);
  endtask
  // channels 0 and 3 pending together after channel 2 was last: 3 must win
  task automatic t_rotate;
    wr(4'hB, 8'h40);
    req = 4'h9;
    wr(4'hE, 8'h00);
    serve(4'h8);
    serve(4'h1);
    req = 4'h0;
    cyc(40);
    chk(bus_hold_request, 1'b0);
    rd(4'h8, r);
    chk(r[3:0], 4'h8);
  endtask
  // memory move of one byte from 0x0300 to 0x0400; the bus holds 8'h5B after the request write
  task automatic t_m2m;
    wr(4'h8, 8'h01);
    wr(4'hC, 8'h00);
    wr(4'h0, 8'h00);
    wr(4'h0, 8'h03);
    wr(4'h2, 8'h00);
    wr(4'h2, 8'h04);
    wr(4'h3, 8'h00);
    wr(4'h3, 8'h00);
    wr(4'h9, 8'hA4);
    serve(4'h0);
    chk({n_mr > 0, n_mw > 0}, 2'h3);
    chk(16'(n_stb), 16'h2);
    rd(4'hD, r);
    chk(r, 8'h5B);
    rd(4'h8, r);
    chk(r[3:0], 4'h3);
    wr(4'hC, 8'h00);
    rd(4'h0, r);
    chk(r, 8'h01);
    wr(4'hC, 8'h00);
    rd(4'h2, r);
    chk(r, 8'h01);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    cyc(2); rst = 0; cyc(4);
    t_reset;
    t_single;
    t_soft_verify;
    t_block;
    t_rotate;
    t_m2m;
    results;
  end
  initial begin
    #3000000;
    n_mismatch++;
    results;
  end
endmodule
